// >>> src/pgm_pkg.sv
// pad configuration mux: shared register map, field layout and timing
// assumes a 10 MHz core clock and a byte-wide register port
package pgm_pkg;

  // ==========================================================
  // register map
  localparam int          ADDR_W      = 10;
  localparam logic [9:0]  ADDR_PAD23  = 10'h016;
  localparam logic [9:0]  ADDR_PAD4   = 10'h017;
  localparam logic [9:0]  ADDR_WAKE   = 10'h01c;
  localparam logic [9:0]  ADDR_MODE   = 10'h01d;
  localparam logic [9:0]  ADDR_OUT02  = 10'h01e;
  localparam logic [9:0]  ADDR_OUT34  = 10'h01f;

  // reset values
  localparam logic [7:0]  RST_PAD23   = 8'h00;
  localparam logic [7:0]  RST_PAD4    = 8'h00;
  localparam logic [7:0]  RST_WAKE    = 8'h00;
  localparam logic [7:0]  RST_MODE    = 8'h00;
  localparam logic [7:0]  RST_OUT02   = 8'h00;
  localparam logic [7:0]  RST_OUT34   = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED = 8'h00;

  // ==========================================================
  // field positions (low bit of each field)
  localparam int CFG_HI_LSB = 4;
  localparam int CFG_LO_LSB = 0;
  localparam int OUT0_LSB   = 0;
  localparam int OUT1_LSB   = 3;
  localparam int OUT2_LSB   = 6;
  localparam int OUT3_LSB   = 0;
  localparam int OUT4_LSB   = 3;

  // pad function codes
  localparam logic [1:0] FN_ALT = 2'h0;
  localparam logic [1:0] FN_IN  = 2'h1;
  localparam logic [1:0] FN_OD  = 2'h2;
  localparam logic [1:0] FN_PP  = 2'h3;

  // output source codes
  localparam logic [2:0] SRC_STATIC = 3'h0;
  localparam logic [2:0] SRC_FAULT  = 3'h1;
  localparam logic [2:0] SRC_CLK    = 3'h2;
  localparam logic [2:0] SRC_SEQ    = 3'h3;

  // ==========================================================
  // debounce times in ms and their cycle counts
  localparam real CLK_HZ    = 10.0e6;
  localparam real DEB_MS_1  = 0.1;
  localparam real DEB_MS_2  = 1.0;
  localparam real DEB_MS_3  = 10.24;
  localparam real DEB_MS_4  = 51.2;
  localparam real DEB_MS_5  = 256.0;
  localparam real DEB_MS_6  = 512.0;
  localparam real DEB_MS_7  = 1024.0;
  localparam int  DEB_CYC_1 = int'(DEB_MS_1 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_2 = int'(DEB_MS_2 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_3 = int'(DEB_MS_3 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_4 = int'(DEB_MS_4 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_5 = int'(DEB_MS_5 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_6 = int'(DEB_MS_6 * 1.0e-3 * CLK_HZ);
  localparam int  DEB_CYC_7 = int'(DEB_MS_7 * 1.0e-3 * CLK_HZ);

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PK_IN, PK_OD, PK_PP, PK_FAULT, PK_RSV
  } pgm_kind_t;

  typedef struct packed {
    logic       wake_block;
    logic       polarity;
    logic [1:0] fn_sel;
  } pgm_pad_cfg_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } pgm_reg_req_t;

endpackage

// >>> src/pgm_gpio_mux.sv
// five-pad configuration, input sensing and output source mux
// assumes all inputs are synchronous to clk; register port is
// driven by the 2-wire interface logic elsewhere in the device
//
// What this block does
// - wake bit 0 lets passive-to-active input raise wake; 1 never wakes
// - polarity bit 1 means high is active, 0 means low is active
// - pad 3 function: reserved, input, open-drain, push-pull output
// - pad 2 function: power enable input, input, open-drain, fault out
// - pad 4 function: system enable input, input, open-drain, push-pull
// - wake sense bit per pad: 0 edge, 1 level; bits 7:5 reserved
// - output with static source drives its mode bit value
// - output with other source: mode bit sets polarity, 1 high
// - input pad: mode bit turns debouncing off (0) or on (1)
// - pad 2 source: static, fault, crystal clock, sequencer
// - pad 1 source adds forwards of pads 0, 2, 3; 101 reserved
// - pad 0 source adds forwards of pads 1, 2, 3; 100 reserved
// - pad 4 source: static, fault, clock, sequencer; 7:5 reserved
// - pad 3 source adds forwards of pads 0, 1, 2; 111 reserved
// - global three-bit code picks debounce time, none to 1024 ms
// - input events are suppressed in power-down when disabled
`timescale 1ns/1ps

module pgm_gpio_mux #(
  parameter int unsigned CNT_W     = 24,
  parameter int unsigned DEB_CYC_1 = pgm_pkg::DEB_CYC_1,
  parameter int unsigned DEB_CYC_2 = pgm_pkg::DEB_CYC_2,
  parameter int unsigned DEB_CYC_3 = pgm_pkg::DEB_CYC_3,
  parameter int unsigned DEB_CYC_4 = pgm_pkg::DEB_CYC_4,
  parameter int unsigned DEB_CYC_5 = pgm_pkg::DEB_CYC_5,
  parameter int unsigned DEB_CYC_6 = pgm_pkg::DEB_CYC_6,
  parameter int unsigned DEB_CYC_7 = pgm_pkg::DEB_CYC_7
) (
  input  wire logic                 clk,            // core clock
  input  wire logic                 reset_n,        // async reset
  input  wire pgm_pkg::pgm_reg_req_t reg_req,       // register access
  output logic [7:0]                rd_data_q,      // read data
  output logic                      rd_valid_q,     // read data valid
  input  wire logic [7:0]           pad0_1_config,  // pads 0/1 config
  input  wire logic [2:0]           debounce_sel,   // debounce time
  input  wire logic                 gpi_pd_disable, // events off in pd
  input  wire logic                 in_powerdown,   // power-down state
  input  wire logic                 supply_fault_flag_n, // fault, low
  input  wire logic                 crystal_clock_out,   // 32 kHz clk
  input  wire logic [4:0]           seq_out,        // sequencer drive
  input  wire logic [4:0]           pad_in,         // pad levels
  output logic [4:0]                pad_out,        // pad drive value
  output logic [4:0]                pad_oe,         // pad drive enable
  output logic [4:0]                general_purpose_input, // active lv
  output logic [4:0]                input_pad_event, // rise pulse
  output logic [4:0]                wake_request,   // wake-up request
  output logic                      power_domain_enable_in,  // pad 2
  output logic                      system_domain_enable_in  // pad 4
);

  // ==========================================================
  // elaboration checks
  if (DEB_CYC_7 >= (64'd1 << CNT_W) || DEB_CYC_1 < 1) begin : g_chk
    $error("debounce counts do not fit the counter");
  end

  // ==========================================================
  // helpers
  function automatic pgm_pkg::pgm_kind_t kind_of(int p,
                                                 logic [1:0] f);
    case (f)
      pgm_pkg::FN_IN: kind_of = pgm_pkg::PK_IN;
      pgm_pkg::FN_OD: kind_of = pgm_pkg::PK_OD;
      pgm_pkg::FN_PP: begin
        kind_of = (p == 2) ? pgm_pkg::PK_FAULT : pgm_pkg::PK_PP;
      end
      default: begin
        // pads 1 and 3 have no alternate input function
        kind_of = (p == 1 || p == 3) ? pgm_pkg::PK_RSV
                                     : pgm_pkg::PK_IN;
      end
    endcase
  endfunction
  // forward codes naming the pad itself are reserved
  function automatic logic src_ok(int p, logic [2:0] code);
    src_ok = !code[2] || (code[1:0] != 2'(p));
  endfunction
  function automatic logic [CNT_W-1:0] deb_lim(logic [2:0] sel);
    case (sel)
      3'h1:    deb_lim = CNT_W'(DEB_CYC_1);
      3'h2:    deb_lim = CNT_W'(DEB_CYC_2);
      3'h3:    deb_lim = CNT_W'(DEB_CYC_3);
      3'h4:    deb_lim = CNT_W'(DEB_CYC_4);
      3'h5:    deb_lim = CNT_W'(DEB_CYC_5);
      3'h6:    deb_lim = CNT_W'(DEB_CYC_6);
      3'h7:    deb_lim = CNT_W'(DEB_CYC_7);
      default: deb_lim = CNT_W'(1);
    endcase
  endfunction

  // ==========================================================
  // registers
  logic [7:0] pad23_q;
  logic [7:0] pad4_q;
  logic [7:0] wake_sense_q;
  logic [7:0] mode_q;
  logic [7:0] out02_q;
  logic [7:0] out34_q;

  // byte writes keep every bit, reserved ones included
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad23_q      <= pgm_pkg::RST_PAD23;
      pad4_q       <= pgm_pkg::RST_PAD4;
      wake_sense_q <= pgm_pkg::RST_WAKE;
      mode_q       <= pgm_pkg::RST_MODE;
      out02_q      <= pgm_pkg::RST_OUT02;
      out34_q      <= pgm_pkg::RST_OUT34;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        pgm_pkg::ADDR_PAD23: pad23_q      <= reg_req.wdata;
        pgm_pkg::ADDR_PAD4:  pad4_q       <= reg_req.wdata;
        pgm_pkg::ADDR_WAKE:  wake_sense_q <= reg_req.wdata;
        pgm_pkg::ADDR_MODE:  mode_q       <= reg_req.wdata;
        pgm_pkg::ADDR_OUT02: out02_q      <= reg_req.wdata;
        pgm_pkg::ADDR_OUT34: out34_q      <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // read returns stored bytes with no side effect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_req.rd;
      if (reg_req.rd) begin
        case (reg_req.addr)
          pgm_pkg::ADDR_PAD23: rd_data_q <= pad23_q;
          pgm_pkg::ADDR_PAD4:  rd_data_q <= pad4_q;
          pgm_pkg::ADDR_WAKE:  rd_data_q <= wake_sense_q;
          pgm_pkg::ADDR_MODE:  rd_data_q <= mode_q;
          pgm_pkg::ADDR_OUT02: rd_data_q <= out02_q;
          pgm_pkg::ADDR_OUT34: rd_data_q <= out34_q;
          default:             rd_data_q <= pgm_pkg::RD_UNMAPPED;
        endcase
      end
    end
  end

  // ==========================================================
  // per-pad field views
  pgm_pkg::pgm_pad_cfg_t cfg [5];
  logic [2:0]            src [5];

  assign cfg[0] = pad0_1_config[pgm_pkg::CFG_LO_LSB +: 4];
  assign cfg[1] = pad0_1_config[pgm_pkg::CFG_HI_LSB +: 4];
  assign cfg[2] = pad23_q[pgm_pkg::CFG_LO_LSB +: 4];
  assign cfg[3] = pad23_q[pgm_pkg::CFG_HI_LSB +: 4];
  assign cfg[4] = pad4_q[pgm_pkg::CFG_LO_LSB +: 4];
  // two-bit selectors widen to the three-bit code space
  assign src[0] = out02_q[pgm_pkg::OUT0_LSB +: 3];
  assign src[1] = out02_q[pgm_pkg::OUT1_LSB +: 3];
  assign src[2] = {1'b0, out02_q[pgm_pkg::OUT2_LSB +: 2]};
  assign src[3] = out34_q[pgm_pkg::OUT3_LSB +: 3];
  assign src[4] = {1'b0, out34_q[pgm_pkg::OUT4_LSB +: 2]};
  logic [4:0]       gpi_v;
  logic [CNT_W-1:0] lim;
  assign lim = deb_lim(debounce_sel);

  // ==========================================================
  // pad slices
  for (genvar i = 0; i < 5; i++) begin : g_pad
    pgm_pkg::pgm_kind_t kind;
    logic               is_in, act_raw, deb_on, rise, src_act, val;
    logic [CNT_W-1:0]   cnt_q;
    logic               lvl_q, prev_q, wake_q, evt_q, out_q, oe_q;
    assign kind    = kind_of(i, cfg[i].fn_sel);
    assign is_in   = (kind == pgm_pkg::PK_IN);
    assign act_raw = pad_in[i] ~^ cfg[i].polarity;
    assign deb_on  = is_in && mode_q[i]
                     && (debounce_sel != 3'h0);
    assign rise    = lvl_q && !prev_q;
    // filtered active level: a change must persist for the full time
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        lvl_q <= 1'b0;
        cnt_q <= '0;
      end else if (!deb_on || act_raw == lvl_q) begin
        lvl_q <= act_raw;
        cnt_q <= '0;
      end else if (cnt_q >= lim - CNT_W'(1)) begin
        lvl_q <= act_raw;
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
    // wake and event detection on the filtered level
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        prev_q <= 1'b0;
        wake_q <= 1'b0;
        evt_q  <= 1'b0;
      end else begin
        prev_q <= lvl_q;
        wake_q <= is_in && !cfg[i].wake_block
                  && (wake_sense_q[i] ? lvl_q : rise);
        evt_q  <= is_in && rise
                  && !(in_powerdown && gpi_pd_disable);
      end
    end
    // source value before polarity
    always_comb begin
      case (src[i])
        pgm_pkg::SRC_FAULT: src_act = !supply_fault_flag_n;
        pgm_pkg::SRC_CLK:   src_act = crystal_clock_out;
        pgm_pkg::SRC_SEQ:   src_act = seq_out[i];
        default:            src_act = gpi_v[src[i][1:0]];
      endcase
    end
    assign val = (src[i] == pgm_pkg::SRC_STATIC) ? mode_q[i]
               : (src_act ~^ mode_q[i]);
    // pad drive; reserved selections leave the pad undriven
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        out_q <= 1'b0;
        oe_q  <= 1'b0;
      end else begin
        case (kind)
          pgm_pkg::PK_OD: begin
            out_q <= 1'b0;
            oe_q  <= src_ok(i, src[i]) && !val;
          end
          pgm_pkg::PK_PP: begin
            out_q <= val;
            oe_q  <= src_ok(i, src[i]);
          end
          pgm_pkg::PK_FAULT: begin
            out_q <= supply_fault_flag_n;
            oe_q  <= 1'b1;
          end
          default: begin
            out_q <= 1'b0;
            oe_q  <= 1'b0;
          end
        endcase
      end
    end
    assign gpi_v[i]                 = lvl_q;
    assign general_purpose_input[i] = lvl_q;
    assign wake_request[i]          = wake_q;
    assign input_pad_event[i]       = evt_q;
    assign pad_out[i]               = out_q;
    assign pad_oe[i]                = oe_q;
  end

  // ==========================================================
  // dedicated domain enable inputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_domain_enable_in  <= 1'b0;
      system_domain_enable_in <= 1'b0;
    end else begin
      power_domain_enable_in  <= (cfg[2].fn_sel == pgm_pkg::FN_ALT)
                                 && gpi_v[2];
      system_domain_enable_in <= (cfg[4].fn_sel == pgm_pkg::FN_ALT)
                                 && gpi_v[4];
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_wake_blocked;
    cfg[3].wake_block |=> !wake_request[3];
  endproperty
  a_wake_blocked: assert property (p_wake_blocked)
    else $error("blocked pad 3 raised wake");
  property p_polarity;
    (cfg[2].fn_sel == pgm_pkg::FN_IN) && !mode_q[2]
      |=> general_purpose_input[2]
          == ($past(pad_in[2]) ~^ $past(cfg[2].polarity));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pad 2 active level wrong");
  property p_rsv_fn;
    cfg[3].fn_sel == pgm_pkg::FN_ALT |=> !pad_oe[3] && !wake_request[3];
  endproperty
  a_rsv_fn: assert property (p_rsv_fn)
    else $error("reserved pad 3 function drove or woke");
  property p_fault_out;
    cfg[2].fn_sel == pgm_pkg::FN_PP
      |=> pad_oe[2] && (pad_out[2] == $past(supply_fault_flag_n));
  endproperty
  a_fault_out: assert property (p_fault_out)
    else $error("pad 2 not driving fault flag");
  property p_static;
    (cfg[3].fn_sel == pgm_pkg::FN_PP) && (src[3] == pgm_pkg::SRC_STATIC)
      |=> pad_oe[3] && (pad_out[3] == $past(mode_q[3]));
  endproperty
  a_static: assert property (p_static)
    else $error("pad 3 static value wrong");
  property p_seq_pol;
    (cfg[3].fn_sel == pgm_pkg::FN_PP) && (src[3] == pgm_pkg::SRC_SEQ)
      |=> pad_out[3] == ($past(seq_out[3]) ~^ $past(mode_q[3]));
  endproperty
  a_seq_pol: assert property (p_seq_pol)
    else $error("pad 3 sequencer polarity wrong");
  property p_od_low;
    cfg[3].fn_sel == pgm_pkg::FN_OD |=> !pad_out[3];
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open-drain pad 3 drove high");
  property p_pd_events;
    in_powerdown && gpi_pd_disable |=> input_pad_event == 5'h00;
  endproperty
  a_pd_events: assert property (p_pd_events)
    else $error("event seen in power-down");
  property p_edge_pulse;
    wake_request[2] && !$past(wake_sense_q[2]) && !wake_sense_q[2]
      |=> !wake_request[2];
  endproperty
  a_edge_pulse: assert property (p_edge_pulse)
    else $error("edge wake longer than one cycle");
  property p_readback;
    reg_req.wr && reg_req.addr == pgm_pkg::ADDR_OUT34
      ##1 reg_req.rd && !reg_req.wr
          && reg_req.addr == pgm_pkg::ADDR_OUT34
      |=> rd_valid_q && rd_data_q == $past(reg_req.wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback differs from written byte");

endmodule

// >>> sim/pgm_pad_env.sv
// board-side model of the five pads around the configuration mux
// assumes pull-ups on every pad; the board drives only when enabled
`timescale 1ns/1ps

module pgm_pad_env (
  input  wire logic [4:0] pad_out,   // block drive value
  input  wire logic [4:0] pad_oe,    // block drive enable
  input  wire logic [4:0] ext_drive, // board drives the pad
  input  wire logic [4:0] ext_level, // board drive level
  output logic      [4:0] pad_in     // resolved pad level
);
  // ==========================================================
  // resolution: block drive wins, then board, else the pull-up
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_drive[i]) begin
        pad_in[i] = ext_level[i];
      end else begin
        pad_in[i] = 1'b1;
      end
    end
  end
endmodule

// >>> sim/pmic_gpio_config_mux_test.sv
// self-checking bench for the pad configuration mux
// assumes the pad env model on the pads and short debounce counts
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end

module pmic_gpio_config_mux_test;
  // ==========================================================
  // signals
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  pgm_pkg::pgm_reg_req_t reg_req;
  logic [7:0]            rd_data_q, pad0_1_config;
  logic                  rd_valid_q, gpi_pd_disable, in_powerdown;
  logic [2:0]            debounce_sel;
  logic                  supply_fault_flag_n, crystal_clock_out;
  logic [4:0]            seq_out, pad_in, pad_out, pad_oe, ext_drive;
  logic [4:0]            general_purpose_input, input_pad_event;
  logic [4:0]            wake_request, ext_level;
  logic                  power_domain_enable_in, system_domain_enable_in;
  logic                  ev, wk, wk2;
  int                    failures = 0;
  int                    samples_checked = 0;
  logic [9:0] ra [6] = '{pgm_pkg::ADDR_PAD23, pgm_pkg::ADDR_PAD4,
    pgm_pkg::ADDR_WAKE, pgm_pkg::ADDR_MODE, pgm_pkg::ADDR_OUT02,
    pgm_pkg::ADDR_OUT34};
  logic [7:0] rv [6] = '{pgm_pkg::RST_PAD23, pgm_pkg::RST_PAD4,
    pgm_pkg::RST_WAKE, pgm_pkg::RST_MODE, pgm_pkg::RST_OUT02,
    pgm_pkg::RST_OUT34};
  logic [7:0] vt = 8'b0011_1010; // source values for codes 1..6

  // clock at 10 MHz
  always #50 clk = ~clk;

  // short counts for codes 1 to 3, of which the bench uses 3; the rest keep defaults
  pgm_gpio_mux #(.DEB_CYC_1(2), .DEB_CYC_2(3), .DEB_CYC_3(4)) DUT (
    .clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .pad0_1_config(pad0_1_config), .debounce_sel(debounce_sel),
    .gpi_pd_disable(gpi_pd_disable), .in_powerdown(in_powerdown),
    .supply_fault_flag_n(supply_fault_flag_n),
    .crystal_clock_out(crystal_clock_out), .seq_out(seq_out),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .general_purpose_input(general_purpose_input),
    .input_pad_event(input_pad_event), .wake_request(wake_request),
    .power_domain_enable_in(power_domain_enable_in),
    .system_domain_enable_in(system_domain_enable_in));

  pgm_pad_env u_env (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_drive(ext_drive), .ext_level(ext_level), .pad_in(pad_in));

  // ==========================================================
  // tasks
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask

  task automatic reg_rd(input logic [9:0] a, input logic [7:0] ex);
    int n;
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    n = 0;
    while (rd_valid_q !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("rd_valid_q", 1'b1, rd_valid_q)
    `CHK("rd_data_q", ex, rd_data_q)
  endtask

  // drops then raises one pad, samples event and wake after the rise
  task automatic rise(input int i);
    @(posedge clk);
    ext_level[i] <= 1'b0;
    repeat (4) @(posedge clk);
    ext_level[i] <= 1'b1;
    settle(2);
    ev = input_pad_event[i];
    wk = wake_request[i];
    settle(1);
    wk2 = wake_request[i];
  endtask

  // config address 0 means the pads 0/1 config input
  task automatic out_case(input logic [9:0] ca, input logic [7:0] cd,
      input logic [9:0] sa, input logic [7:0] sd, input logic [7:0] md,
      input int i, input logic eo, input logic ee);
    if (ca == 10'h000) begin
      @(posedge clk);
      pad0_1_config <= cd;
    end else begin
      reg_wr(ca, cd);
    end
    reg_wr(sa, sd);
    reg_wr(pgm_pkg::ADDR_MODE, md);
    settle(4);
    `CHK("pad_oe", ee, pad_oe[i])
    if (ee === 1'b1) `CHK("pad_out", eo, pad_out[i])
  endtask

  // ==========================================================
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    reg_req = '0;
    pad0_1_config = 8'h95;
    debounce_sel = 3'h0;
    gpi_pd_disable = 1'b0;
    in_powerdown = 1'b0;
    supply_fault_flag_n = 1'b0;
    crystal_clock_out = 1'b0;
    seq_out = 5'h1f;
    ext_drive = 5'h1f;
    ext_level = 5'h00;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 6; k++) reg_rd(ra[k], rv[k]);
    settle(3);
    `CHK("power_domain_enable_in", 1'b1, power_domain_enable_in)
    `CHK("system_domain_enable_in", 1'b1, system_domain_enable_in)
    @(posedge clk);
    ext_level <= 5'h14;
    settle(3);
    `CHK("power_domain_enable_in", 1'b0, power_domain_enable_in)
    `CHK("system_domain_enable_in", 1'b0, system_domain_enable_in)
    for (int k = 0; k < 6; k++) reg_wr(ra[k], 8'ha5 ^ 8'(k));
    reg_wr(10'h01a, 8'hff);
    reg_rd(10'h01a, pgm_pkg::RD_UNMAPPED);
    for (int k = 0; k < 6; k++) reg_rd(ra[k], 8'ha5 ^ 8'(k));
    // write then read in the very next cycle returns the new byte
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: pgm_pkg::ADDR_OUT34,
                 wdata: 8'h5a};
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: pgm_pkg::ADDR_OUT34,
                 wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    #1;
    `CHK("rd_valid_q b2b", 1'b1, rd_valid_q)
    `CHK("rd_data_q b2b", 8'h5a, rd_data_q)
    for (int k = 0; k < 6; k++) reg_wr(ra[k], 8'h00);
    // input sensing and wake
    rise(0);
    `CHK("gpi0", 1'b1, general_purpose_input[0])
    `CHK("event0", 1'b1, ev)
    `CHK("wake0", 1'b1, wk)
    `CHK("wake0 edge", 1'b0, wk2)
    @(posedge clk);
    pad0_1_config <= 8'h9d;
    rise(0);
    `CHK("wake0 blocked", 1'b0, wk)
    @(posedge clk);
    pad0_1_config <= 8'h95;
    reg_wr(pgm_pkg::ADDR_WAKE, 8'h01);
    rise(0);
    `CHK("wake0 level", 1'b1, wk)
    `CHK("wake0 held", 1'b1, wk2)
    reg_wr(pgm_pkg::ADDR_WAKE, 8'h00);
    @(posedge clk);
    pad0_1_config <= 8'h91;
    rise(0);
    `CHK("event0 low act", 1'b0, ev)
    `CHK("gpi0 low act", 1'b0, general_purpose_input[0])
    @(posedge clk);
    pad0_1_config <= 8'h95;
    in_powerdown <= 1'b1;
    gpi_pd_disable <= 1'b1;
    rise(0);
    `CHK("event0 pd", 1'b0, ev)
    @(posedge clk);
    in_powerdown <= 1'b0;
    gpi_pd_disable <= 1'b0;
    // debounce
    reg_wr(pgm_pkg::ADDR_MODE, 8'h01);
    debounce_sel <= 3'h3;
    ext_level[0] <= 1'b0;
    settle(12);
    `CHK("gpi0 deb low", 1'b0, general_purpose_input[0])
    @(posedge clk);
    ext_level[0] <= 1'b1;
    settle(2);
    `CHK("gpi0 deb wait", 1'b0, general_purpose_input[0])
    settle(8);
    `CHK("gpi0 deb done", 1'b1, general_purpose_input[0])
    @(posedge clk);
    debounce_sel <= 3'h0;
    ext_level[0] <= 1'b0;
    settle(2);
    `CHK("gpi0 no deb", 1'b0, general_purpose_input[0])
    @(posedge clk);
    ext_level <= 5'h01;
    // output sources, every pad 3 code in both mode values; the first
    // pass inverts the fault, clock and sequencer sources
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      supply_fault_flag_n <= s[0];
      crystal_clock_out   <= s[0];
      seq_out             <= {5{!s[0]}};
      for (int c = 0; c < 8; c++) begin
        for (int m = 0; m < 2; m++) begin
          out_case(pgm_pkg::ADDR_PAD23, 8'hf5, pgm_pkg::ADDR_OUT34, 8'(c),
            8'(m << 3), 3, (c == 0) ? m[0]
            : ((vt[c] ^ (s[0] && c > 0 && c < 4)) ~^ m[0]),
            c != 7);
        end
      end
    end
    out_case(pgm_pkg::ADDR_PAD23, 8'he5, pgm_pkg::ADDR_OUT34, 8'h00,
      8'h08, 3, 1'b0, 1'b0);
    out_case(pgm_pkg::ADDR_PAD23, 8'he5, pgm_pkg::ADDR_OUT34, 8'h00,
      8'h00, 3, 1'b0, 1'b1);
    out_case(pgm_pkg::ADDR_PAD23, 8'hc5, pgm_pkg::ADDR_OUT34, 8'h00,
      8'h08, 3, 1'b0, 1'b0);
    out_case(pgm_pkg::ADDR_PAD23, 8'h5f, pgm_pkg::ADDR_OUT02, 8'h00,
      8'h00, 2, 1'b0, 1'b1);
    out_case(pgm_pkg::ADDR_PAD23, 8'h5e, pgm_pkg::ADDR_OUT02, 8'h80,
      8'h04, 2, 1'b0, 1'b1);
    out_case(pgm_pkg::ADDR_PAD23, 8'h5e, pgm_pkg::ADDR_OUT02, 8'hc0,
      8'h04, 2, 1'b0, 1'b0);
    out_case(pgm_pkg::ADDR_PAD4, 8'h07, pgm_pkg::ADDR_OUT34, 8'h18,
      8'h00, 4, 1'b0, 1'b1);
    out_case(10'h000, 8'h97, pgm_pkg::ADDR_OUT02, 8'h05,
      8'h01, 0, 1'b1, 1'b1);
    out_case(10'h000, 8'h97, pgm_pkg::ADDR_OUT02, 8'h04,
      8'h01, 0, 1'b0, 1'b0);
    out_case(10'h000, 8'hb5, pgm_pkg::ADDR_OUT02, 8'h20,
      8'h02, 1, 1'b1, 1'b1);
    out_case(10'h000, 8'hb5, pgm_pkg::ADDR_OUT02, 8'h28,
      8'h02, 1, 1'b0, 1'b0);
    finish_test();
  end
endmodule
